// *** acos_cutoff.sv ***
// Purpose: High-pass cutoff lookup from selection, data rate and oversampling mode
// Assumes: Rate index 0..7 stands for 800 down to 1.56 Hz
// Notes: Output in 1/32 Hz units; each code step halves the cutoff
`timescale 1ns/1ps
module acos_cutoff import acos_pkg::*; (
  input wire logic [1:0] sel_in,
  input wire logic [2:0] rate_in,
  input wire acos_osm_t osm_in,
  output logic [9:0] cutoff_out
);
  logic [3:0] shift;
  logic [2:0] rate_shift;
  always_comb begin
    rate_shift = 3'd0;
    case (osm_in)
      OSM_NORMAL: rate_shift = (rate_in <= 3'd1) ? 3'd0 : (rate_in >= 3'd4 ? 3'd3 : rate_in - 3'd1);
      OSM_LNLP: rate_shift = (rate_in <= 3'd1) ? 3'd0 : (rate_in >= 3'd5 ? 3'd5 : rate_in - 3'd1);
      OSM_HIRES: rate_shift = 3'd0;
      OSM_LP: rate_shift = (rate_in >= 3'd5) ? 3'd6 : rate_in;
      default: rate_shift = 3'd0;
    endcase
    shift = {2'b00, sel_in} + {1'b0, rate_shift};
  end
  assign cutoff_out = CUT_16HZ >> shift;
endmodule : acos_cutoff

// *** acos_host.sv ***
// Purpose: host register port model. Assumes: byte access. Notes: one-cycle strobes
`timescale 1ns/1ps
module acos_host (
  input wire logic clk_in,
  output logic wr_out = 1'b0,
  output logic rd_out = 1'b0,
  output logic [7:0] addr_out = 8'h00,
  output logic [7:0] wdata_out = 8'h00
);
  // Strobe held to the taking edge, then one idle cycle so results have landed
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    {wr_out, rd_out, addr_out} <= {w, !w, a};
    wdata_out <= d;
    @(posedge clk_in);
    {wr_out, rd_out} <= 2'b00;
    @(posedge clk_in);
    #1;
  endtask : acc
endmodule : acos_host

// *** acos_pkg.sv ***
// Purpose: Shared constants and types for the accelerometer output and orientation block
// Assumes: Register access is a simple synchronous read/write port from the serial front end
// Notes: Cutoff codes are expressed in units of 1/32 Hz
// How it works
// - High-pass enable selects filtered output samples
// - Range field picks 2g, 4g, 8g; 11 reserved
// - Reset gives 2g range, output filtering off
// - Cutoff depends on selection and data rate
// - Cutoff select resets 00; high-res fixed
// - Pulse bypass bit skips pulse high-pass
// - Pulse smoothing bit enables pulse low-pass
// - Status layout: change, trip, orientation, face
// - Any field change sets change flag
// - First detection after activation sets flag
// - Reading status clears change flag, interrupt
// - Trip flag shows tilt lockout exceeded
// - Orientation codes: up, down, right, left
// - Face bit: 0 front, 1 back
// - Status fields zero after power-up
// - Fields keep updating while flag set
// - Orientation held above 1.25g on axis
// - Interrupt source follows flag and enable
// - Detection runs only when enabled
package acos_pkg;
  localparam logic [7:0] ADDR_OUT_CFG = 8'h0E;
  localparam logic [7:0] ADDR_HP_CFG = 8'h0F;
  localparam logic [7:0] ADDR_OR_STAT = 8'h10;
  localparam int HPOUT_BIT = 4;
  localparam int PBYP_BIT = 5;
  localparam int PLPF_BIT = 4;
  localparam logic [7:0] OUT_CFG_MASK = 8'h13;
  localparam logic [7:0] HP_CFG_MASK = 8'h33;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [1:0] FS_2G = 2'b00;
  localparam logic [1:0] FS_4G = 2'b01;
  localparam logic [1:0] FS_8G = 2'b10;
  localparam logic [1:0] FS_RSVD = 2'b11;
  localparam logic [3:0] G_2 = 4'h2;
  localparam logic [3:0] G_4 = 4'h4;
  localparam logic [3:0] G_8 = 4'h8;
  // Lock limit 1.25g in units of 1/4 g
  localparam logic [7:0] LOCK_LIMIT_QG = 8'h05;
  // Cutoff at 16 Hz in 1/32 Hz units
  localparam logic [9:0] CUT_16HZ = 10'h200;
  typedef enum logic [1:0] {
    OSM_NORMAL = 2'b00, OSM_LNLP = 2'b01, OSM_HIRES = 2'b10, OSM_LP = 2'b11
  } acos_osm_t;
  typedef struct packed {
    logic lock;
    logic [1:0] orient;
    logic face;
  } acos_orient_t;
endpackage : acos_pkg

// *** acos_properties.sv ***
// Purpose: port assertions for acos_top. Assumes: ce_in high. Notes: config writes settle in 2
`timescale 1ns/1ps
module acos_properties import acos_pkg::*; (
  input wire logic sys_clk_in, input wire logic rstn_in,
  input wire logic reg_wr_in, input wire logic reg_rd_in,
  input wire logic [7:0] reg_addr_in, input wire logic [7:0] reg_wdata_in,
  input wire logic orient_int_en_in, input wire logic det_valid_in,
  input wire logic [7:0] reg_rdata_out, input wire logic [3:0] full_scale_g_out,
  input wire logic pulse_hp_apply_out, input wire logic pulse_lp_apply_out,
  input wire logic orient_int_src_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);
  wire w_out = reg_wr_in && reg_addr_in == ADDR_OUT_CFG;
  wire w_hp = reg_wr_in && reg_addr_in == ADDR_HP_CFG;
  wire r_st = reg_rd_in && reg_addr_in == ADDR_OR_STAT;
  a_range_code: assert property (w_out && reg_wdata_in[1:0] != FS_RSVD
    |-> ##2 full_scale_g_out == 4'h2 << $past(reg_wdata_in[1:0], 2)) else $error("range");
  a_rsvd_keep: assert property (w_out && reg_wdata_in[1:0] == FS_RSVD
    |-> ##2 full_scale_g_out == $past(full_scale_g_out, 2)) else $error("reserved");
  a_pulse_byp: assert property (w_hp
    |-> ##2 pulse_hp_apply_out == !$past(reg_wdata_in[PBYP_BIT], 2)) else $error("bypass");
  a_pulse_lpf: assert property (w_hp
    |-> ##2 pulse_lp_apply_out == $past(reg_wdata_in[PLPF_BIT], 2)) else $error("smooth");
  a_stat_zeros: assert property (r_st |=> reg_rdata_out[5:3] == 3'h0) else $error("zeros");
  a_read_clr: assert property (r_st && !det_valid_in |=> !orient_int_src_out) else $error("clr");
  a_int_gate: assert property (!orient_int_en_in |-> !orient_int_src_out) else $error("gate");
  a_int_cause: assert property ($rose(orient_int_src_out)
    |-> $past(det_valid_in) || $rose(orient_int_en_in)) else $error("cause");
endmodule : acos_properties
bind acos_top acos_properties u_props (.sys_clk_in, .rstn_in, .reg_wr_in, .reg_rd_in,
  .reg_addr_in, .reg_wdata_in, .orient_int_en_in, .det_valid_in, .reg_rdata_out,
  .full_scale_g_out, .pulse_hp_apply_out, .pulse_lp_apply_out, .orient_int_src_out);

// *** acos_top.sv ***
// Purpose: Output configuration, high-pass setup and orientation status registers
// Assumes: Orientation detector supplies a result strobe with its fields and axis magnitudes
// Notes: Register port is the serial front end's byte access; all state freezes when ce is low
`timescale 1ns/1ps
module acos_top import acos_pkg::*; (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [2:0] rate_in,
  input wire acos_osm_t osm_in,
  input wire logic active_in,
  input wire logic orient_en_in,
  input wire logic orient_int_en_in,
  input wire logic det_valid_in,
  input wire acos_orient_t det_in,
  input wire logic [7:0] axis_x_qg_in,
  input wire logic [7:0] axis_y_qg_in,
  input wire logic [7:0] axis_z_qg_in,
  input wire logic [11:0] raw_sample_in,
  input wire logic [11:0] hp_sample_in,
  output logic [7:0] reg_rdata_out,
  output logic [11:0] out_sample_out,
  output logic [3:0] full_scale_g_out,
  output logic [9:0] cutoff_out,
  output logic pulse_hp_apply_out,
  output logic pulse_lp_apply_out,
  output logic orient_int_src_out
);
  // ***************************************************
  // Configuration registers
  // ***************************************************
  logic [7:0] out_cfg_r;
  logic [7:0] hp_cfg_r;
  wire wr_out_cfg = reg_wr_in && (reg_addr_in == ADDR_OUT_CFG);
  wire wr_hp_cfg = reg_wr_in && (reg_addr_in == ADDR_HP_CFG);
  wire rd_stat = reg_rd_in && (reg_addr_in == ADDR_OR_STAT);
  wire hp_out_en = out_cfg_r[HPOUT_BIT];
  wire [1:0] fs_sel = out_cfg_r[1:0];

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      out_cfg_r <= CFG_RST;
      hp_cfg_r <= CFG_RST;
    end else if (ce_in) begin
      // Unused bits are masked so they always read zero
      if (wr_out_cfg) out_cfg_r <= reg_wdata_in & OUT_CFG_MASK;
      if (wr_hp_cfg) hp_cfg_r <= reg_wdata_in & HP_CFG_MASK;
    end
  end

  // ***************************************************
  // Data path and filter steering
  // ***************************************************
  logic [11:0] out_sample_r;
  logic [3:0] fs_g_r;
  logic [3:0] fs_g_nxt;
  always_comb begin
    case (fs_sel)
      FS_2G: fs_g_nxt = G_2;
      FS_4G: fs_g_nxt = G_4;
      FS_8G: fs_g_nxt = G_8;
      // Reserved code keeps the previous range rather than guessing
      default: fs_g_nxt = fs_g_r;
    endcase
  end
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      out_sample_r <= 12'h000;
      fs_g_r <= G_2;
    end else if (ce_in) begin
      out_sample_r <= hp_out_en ? hp_sample_in : raw_sample_in;
      fs_g_r <= fs_g_nxt;
    end
  end
  assign out_sample_out = out_sample_r;
  assign full_scale_g_out = fs_g_r;
  assign pulse_hp_apply_out = ~hp_cfg_r[PBYP_BIT];
  assign pulse_lp_apply_out = hp_cfg_r[PLPF_BIT];

  logic [9:0] cutoff_w;
  logic [9:0] cutoff_r;
  acos_cutoff u_cutoff (
    .sel_in(hp_cfg_r[1:0]),
    .rate_in(rate_in),
    .osm_in(osm_in),
    .cutoff_out(cutoff_w)
  );
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) cutoff_r <= CUT_16HZ;
    else if (ce_in) cutoff_r <= cutoff_w;
  end
  assign cutoff_out = cutoff_r;

  // ***************************************************
  // Orientation status
  // ***************************************************
  acos_orient_t stat_r;
  logic change_r;
  logic first_pend_r;
  logic active_d_r;
  // Per-axis lock test; any single axis past the limit freezes the reported position
  wire [7:0] axis_mag [3];
  wire [2:0] axis_over;
  assign axis_mag[0] = axis_x_qg_in;
  assign axis_mag[1] = axis_y_qg_in;
  assign axis_mag[2] = axis_z_qg_in;
  for (genvar a = 0; a < 3; a++) begin : g_axis
    assign axis_over[a] = axis_mag[a] > LOCK_LIMIT_QG;
  end
  wire over_lim = |axis_over;
  wire take = det_valid_in && orient_en_in && !over_lim;
  wire differs = take && (det_in != stat_r);
  wire first_hit = take && first_pend_r;
  wire set_chg = differs || first_hit;

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      stat_r <= '0;
      change_r <= 1'b0;
      first_pend_r <= 1'b0;
      active_d_r <= 1'b0;
    end else if (ce_in) begin
      active_d_r <= active_in;
      if (active_in && !active_d_r) first_pend_r <= 1'b1;
      else if (take) first_pend_r <= 1'b0;
      // Fields track the detector even while the flag is pending
      if (take) stat_r <= det_in;
      // A new event in the read cycle survives the clear
      if (set_chg) change_r <= 1'b1;
      else if (rd_stat) change_r <= 1'b0;
    end
  end
  assign orient_int_src_out = change_r && orient_int_en_in;

  // ***************************************************
  // Read mux
  // ***************************************************
  wire [7:0] stat_byte = {change_r, stat_r.lock, 3'b000, stat_r.orient, stat_r.face};
  logic [7:0] rdata_r;
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) rdata_r <= 8'h00;
    else if (ce_in && reg_rd_in) begin
      case (reg_addr_in)
        ADDR_OUT_CFG: rdata_r <= out_cfg_r;
        ADDR_HP_CFG: rdata_r <= hp_cfg_r;
        ADDR_OR_STAT: rdata_r <= stat_byte;
        default: rdata_r <= 8'h00;
      endcase
    end
  end
  assign reg_rdata_out = rdata_r;
endmodule : acos_top

// *** acos_top_tb_top.sv ***
// Purpose: bench for acos_top. Assumes: ce_in high. Notes: detector results injected directly
`timescale 1ns/1ps
module acos_top_tb_top import acos_pkg::*;;
  logic sys_clk_in = 1'b0, rstn_in = 1'b0, reg_wr_in, reg_rd_in, active_in = 1'b0;
  logic orient_en_in = 1'b1, orient_int_en_in = 1'b0, det_valid_in = 1'b0;
  logic [7:0] reg_addr_in, reg_wdata_in, axis_x_qg_in = 8'h00, reg_rdata_out;
  logic [2:0] rate_in = 3'h0;
  acos_osm_t osm_in = OSM_NORMAL;
  acos_orient_t det_in = '0;
  logic [11:0] out_sample_out;
  logic [9:0] cutoff_out;
  logic [3:0] full_scale_g_out;
  logic pulse_hp_apply_out, pulse_lp_apply_out, orient_int_src_out;
  int error_cnt = 0, n_checks = 0, cyc = 0;
  always #4 sys_clk_in = ~sys_clk_in;
  acos_host host (.clk_in(sys_clk_in), .wr_out(reg_wr_in), .rd_out(reg_rd_in),
    .addr_out(reg_addr_in), .wdata_out(reg_wdata_in));
  acos_top uut (.sys_clk_in, .rstn_in, .ce_in(1'b1), .reg_wr_in, .reg_rd_in, .reg_addr_in,
    .reg_wdata_in, .rate_in, .osm_in, .active_in, .orient_en_in, .orient_int_en_in,
    .det_valid_in, .det_in, .axis_x_qg_in, .axis_y_qg_in(8'h00), .axis_z_qg_in(8'h00),
    .raw_sample_in(12'h05A), .hp_sample_in(12'h0A5), .reg_rdata_out, .out_sample_out,
    .full_scale_g_out, .cutoff_out, .pulse_hp_apply_out, .pulse_lp_apply_out,
    .orient_int_src_out);
  task automatic chk(input logic [11:0] s, input logic [11:0] e);
    n_checks++;
    error_cnt += int'(s !== e);
    if (s !== e) $display("unexpected t=%0t seen=%h exp=%h", $time, s, e);
  endtask : chk
  task automatic rd_st(input logic [7:0] e);
    host.acc(1'b0, ADDR_OR_STAT, 8'h00);
    chk(reg_rdata_out, e);
  endtask : rd_st
  task automatic pos(input logic [3:0] f, input logic [7:0] a);
    @(posedge sys_clk_in);
    {det_valid_in, det_in, axis_x_qg_in} <= {1'b1, f, a};
    @(posedge sys_clk_in);
    det_valid_in <= 1'b0;
    @(posedge sys_clk_in);
    #1;
  endtask : pos
  task automatic t_cfg;
    chk(full_scale_g_out, G_2);
    chk(cutoff_out, CUT_16HZ);
    chk({pulse_hp_apply_out, pulse_lp_apply_out}, 2'b10);
    rd_st(8'h00);
    for (int i = 0; i < 4; i++) begin
      host.acc(1'b1, ADDR_HP_CFG, 8'(i) | 8'h30);
      host.acc(1'b1, ADDR_OUT_CFG, 8'(i) | 8'h10);
      chk(cutoff_out, CUT_16HZ >> i);
      chk(full_scale_g_out, i < 3 ? 4'h2 << i : G_8);
      chk(out_sample_out, 12'h0A5);
    end
    chk({pulse_hp_apply_out, pulse_lp_apply_out}, 2'b01);
    @(posedge sys_clk_in);
    osm_in <= OSM_HIRES;
    rate_in <= 3'h7;
    host.acc(1'b0, 8'h20, 8'h00);
    chk(reg_rdata_out, 8'h00);
    chk(cutoff_out, 10'h040);
    @(posedge sys_clk_in);
    osm_in <= OSM_LP;
    host.acc(1'b0, ADDR_HP_CFG, 8'h00);
    chk(reg_rdata_out, 8'h33);
    chk(cutoff_out, 10'h001);
    @(posedge sys_clk_in);
    osm_in <= OSM_LNLP;
    host.acc(1'b0, ADDR_OUT_CFG, 8'h00);
    chk(reg_rdata_out, 8'h13);
    chk(cutoff_out, 10'h002);
    @(posedge sys_clk_in);
    osm_in <= OSM_NORMAL;
    rate_in <= 3'h2;
    host.acc(1'b1, ADDR_OUT_CFG, 8'h00);
    chk(cutoff_out, 10'h020);
    chk(out_sample_out, 12'h05A);
    $display("config test done");
  endtask : t_cfg
  task automatic t_orient;
    @(posedge sys_clk_in);
    active_in <= 1'b1;
    pos(4'h0, 8'h00);
    chk(orient_int_src_out, 1'b0);
    @(posedge sys_clk_in);
    orient_int_en_in <= 1'b1;
    #1;
    chk(orient_int_src_out, 1'b1);
    rd_st(8'h80);
    chk(orient_int_src_out, 1'b0);
    pos(4'hF, 8'h00);
    rd_st(8'hC7);
    pos(4'h4, 8'h00);
    pos(4'h2, 8'h00);
    rd_st(8'h82);
    pos(4'hF, 8'h06);
    rd_st(8'h02);
    pos(4'h0, 8'h05);
    rd_st(8'h80);
    @(posedge sys_clk_in);
    orient_en_in <= 1'b0;
    pos(4'hF, 8'h00);
    rd_st(8'h00);
    $display("orientation test done");
  endtask : t_orient
  task automatic t_reset;
    @(posedge sys_clk_in);
    rstn_in <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
    rstn_in <= 1'b1;
    @(posedge sys_clk_in);
    #1;
    chk(full_scale_g_out, G_2);
    chk(out_sample_out, 12'h05A);
    chk(cutoff_out, CUT_16HZ >> 1);
    chk({pulse_hp_apply_out, pulse_lp_apply_out}, 2'b10);
    rd_st(8'h00);
    $display("reset test done");
  endtask : t_reset
  task automatic end_sim;
    error_cnt += int'(cyc > 2000);
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_sim
  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc > 2000) end_sim();
  end
  initial begin
    repeat (5) @(posedge sys_clk_in);
    rstn_in <= 1'b1;
    t_cfg();
    t_orient();
    t_reset();
    end_sim();
  end
endmodule : acos_top_tb_top
